/* hw/pio_pkg.sv */
/*
 Constants shared by the parallel port block: register offsets,
 port widths, field positions and values after reset.
 Assumes an 8-bit register port with byte offsets.
*/
package pio_pkg;
   localparam int unsigned PIO_AW = 8;
   localparam int unsigned PIO_DW = 8;
   localparam int unsigned PIO_C_W = 5;
   localparam int unsigned PIO_D_W = 2;
   localparam int unsigned PIO_E_W = 2;
   localparam logic [7:0] PIO_PORT_C_PIN_DATA_OFF = 8'h02;
   localparam logic [7:0] PIO_PORT_D_PIN_DATA_OFF = 8'h03;
   localparam logic [7:0] PIO_PORT_E_PIN_DATA_OFF = 8'h08;
   localparam logic [7:0] PIO_PORT_C_DIRECTION_OFF = 8'h06;
   localparam logic [7:0] PIO_PORT_D_DIRECTION_OFF = 8'h07;
   localparam logic [7:0] PIO_PORT_E_DIRECTION_OFF = 8'h0c;
   localparam int unsigned PIO_CLK_OUT_BIT = 7;
   localparam int unsigned PIO_CLK_PIN = 2;
   localparam logic PIO_CLK_EN_RST = 1'b0;
   localparam logic [7:0] PIO_DIR_RST = 8'h00;
   localparam logic [7:0] PIO_RDATA_RST = 8'h00;
   localparam logic [7:0] PIO_UNMAPPED_RD = 8'h00;
endpackage

/* hw/pio_pin_bank.sv */
/*
 One bank of bidirectional port pins: a data latch, a direction
 register and the read view that mixes latch and pin level.
 Assumes pin levels are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_pin_bank
   import pio_pkg::*;
#(
   parameter int unsigned W = 2
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register writes
   input wire logic wr_data_in,
   input wire logic wr_dir_in,
   input wire logic [W-1:0] wdata_in,
   // Pin level
   input wire logic [W-1:0] pin_in,
   // State and read view
   output logic [W-1:0] latch_out,
   output logic [W-1:0] dir_out,
   output logic [W-1:0] view_out
);
   logic [W-1:0] latch_q;
   logic [W-1:0] dir_q;

   // Latch takes writes in either direction and keeps its value on reset
   always_ff @(posedge clk_in)
   begin
      if (wr_data_in)
      begin
         latch_q <= wdata_in; // RL5 RL12 RL15
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dir_q <= PIO_DIR_RST[W-1:0]; // RL3 RL9 RL13
      end
      else if (wr_dir_in)
      begin
         dir_q <= wdata_in;
      end
   end

   always_comb
   begin
      view_out = (dir_q & latch_q) | (~dir_q & pin_in); // RL4 RL10 RL14
   end

   assign latch_out = latch_q;
   assign dir_out = dir_q;
endmodule
`default_nettype wire

/* hw/pio_ports.sv */
/*
 Parallel I/O ports C, D and E with data latches, direction
 registers and an optional bus clock output on port C pin 2.
 Assumes a simple register port with one-cycle strobes, read data
 one cycle after the read strobe, and pin levels synchronous to
 the clock. The pad ring resolves pins from the output enables.
*/
// Our own choice: the strobed register port.
//
// How it works
// RL1 - Port C direction bit 1 drives the pin, 0 leaves it input.
// RL2 - Clock output enable drives bus clock on port C pin two.
// RL3 - Reset clears port C direction bits and clock output enable.
// RL4 - Port C read gives latch for outputs, pin level for inputs.
// RL5 - Data latches take writes whatever the direction bit.
// RL6 - Software writes data before turning a pin to output.
// RL7 - Port D has two pins with latch and direction bits.
// RL8 - Port D direction bit 1 drives the pin, 0 leaves it input.
// RL9 - Reset clears both port D direction bits.
// RL10 - Port D read gives latch for outputs, pin level for inputs.
// RL11 - Port E direction bit 1 drives the pin, 0 leaves it input.
// RL12 - Reset leaves port E data latches unchanged.
// RL13 - Reset clears both port E direction bits.
// RL14 - Port E read gives latch for outputs, pin level for inputs.
// RL15 - Reset leaves port C data latches unchanged.
// RL16 - Clock enable sits in direction bit 7; pin two then reads 0.
`timescale 1ns/1ps
`default_nettype none
module pio_ports
   import pio_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [PIO_AW-1:0] addr_in,
   input wire logic [PIO_DW-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [PIO_DW-1:0] rdata_out,
   // Port C pins
   input wire logic [PIO_C_W-1:0] port_c_in,
   output logic [PIO_C_W-1:0] port_c_out,
   output logic [PIO_C_W-1:0] port_c_oe_out,
   // Port D pins
   input wire logic [PIO_D_W-1:0] port_d_in,
   output logic [PIO_D_W-1:0] port_d_out,
   output logic [PIO_D_W-1:0] port_d_oe_out,
   // Port E pins
   input wire logic [PIO_E_W-1:0] port_e_in,
   output logic [PIO_E_W-1:0] port_e_out,
   output logic [PIO_E_W-1:0] port_e_oe_out
);
   function automatic logic pio_hit(
      input logic [PIO_AW-1:0] addr,
      input logic [PIO_AW-1:0] off
   );
      pio_hit = (addr == off);
   endfunction

   function automatic logic [PIO_DW-1:0] pio_pad2(
      input logic [1:0] val
   );
      pio_pad2 = {6'h00, val};
   endfunction

   logic wr_c_data;
   logic wr_d_data;
   logic wr_e_data;
   logic wr_c_dir;
   logic wr_d_dir;
   logic wr_e_dir;
   logic clk_en_q;
   logic [PIO_C_W-1:0] c_oe_q;
   logic [PIO_DW-1:0] rdata_q;
   logic [PIO_DW-1:0] rdata_d;
   logic [PIO_C_W-1:0] c_latch;
   logic [PIO_C_W-1:0] c_dir;
   logic [PIO_C_W-1:0] c_view;
   logic [PIO_C_W-1:0] c_read;
   logic [PIO_D_W-1:0] d_latch;
   logic [PIO_D_W-1:0] d_dir;
   logic [PIO_D_W-1:0] d_view;
   logic [PIO_E_W-1:0] e_latch;
   logic [PIO_E_W-1:0] e_dir;
   logic [PIO_E_W-1:0] e_view;
   logic [PIO_C_W-1:0] clk_pin_mask;

   assign clk_pin_mask = 5'h01 << PIO_CLK_PIN;

   // Write decode
   always_comb
   begin
      wr_c_data = wr_in && pio_hit(addr_in, PIO_PORT_C_PIN_DATA_OFF);
      wr_d_data = wr_in && pio_hit(addr_in, PIO_PORT_D_PIN_DATA_OFF);
      wr_e_data = wr_in && pio_hit(addr_in, PIO_PORT_E_PIN_DATA_OFF);
      wr_c_dir = wr_in && pio_hit(addr_in, PIO_PORT_C_DIRECTION_OFF);
      wr_d_dir = wr_in && pio_hit(addr_in, PIO_PORT_D_DIRECTION_OFF);
      wr_e_dir = wr_in && pio_hit(addr_in, PIO_PORT_E_DIRECTION_OFF);
   end

   pio_pin_bank #(
      .W(PIO_C_W)
   ) u_bank_c (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .wr_data_in(wr_c_data),
      .wr_dir_in(wr_c_dir),
      .wdata_in(wdata_in[PIO_C_W-1:0]),
      .pin_in(port_c_in),
      .latch_out(c_latch),
      .dir_out(c_dir),
      .view_out(c_view)
   );

   pio_pin_bank #(
      .W(PIO_D_W)
   ) u_bank_d (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .wr_data_in(wr_d_data),
      .wr_dir_in(wr_d_dir),
      .wdata_in(wdata_in[PIO_D_W-1:0]),
      .pin_in(port_d_in),
      .latch_out(d_latch),
      .dir_out(d_dir),
      .view_out(d_view)
   );

   pio_pin_bank #(
      .W(PIO_E_W)
   ) u_bank_e (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .wr_data_in(wr_e_data),
      .wr_dir_in(wr_e_dir),
      .wdata_in(wdata_in[PIO_E_W-1:0]),
      .pin_in(port_e_in),
      .latch_out(e_latch),
      .dir_out(e_dir),
      .view_out(e_view)
   );

   // Clock output enable lives in the top bit of port C direction
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clk_en_q <= PIO_CLK_EN_RST; // RL3
      end
      else if (wr_c_dir)
      begin
         clk_en_q <= wdata_in[PIO_CLK_OUT_BIT]; // RL16
      end
   end

   // Port C drive enables kept in their own flop, pin two forced on
   // while it carries the clock, so the pads see no decode glitch
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         c_oe_q <= PIO_DIR_RST[PIO_C_W-1:0]; // RL3
      end
      else if (wr_c_dir)
      begin
         c_oe_q <= wdata_in[PIO_C_W-1:0] |
            (wdata_in[PIO_CLK_OUT_BIT] ? clk_pin_mask : '0); // RL1 RL2
      end
   end

   // Pin two reads 0 while it carries the clock
   always_comb
   begin
      c_read = c_view;
      if (clk_en_q)
      begin
         c_read = c_view & ~clk_pin_mask; // RL16
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      rdata_d = PIO_UNMAPPED_RD;
      case (addr_in)
         PIO_PORT_C_PIN_DATA_OFF:
         begin
            rdata_d = {3'h0, c_read}; // RL4
         end
         PIO_PORT_D_PIN_DATA_OFF:
         begin
            rdata_d = pio_pad2(d_view); // RL10
         end
         PIO_PORT_E_PIN_DATA_OFF:
         begin
            rdata_d = pio_pad2(e_view); // RL14
         end
         PIO_PORT_C_DIRECTION_OFF:
         begin
            rdata_d = {clk_en_q, 2'h0, c_dir};
         end
         PIO_PORT_D_DIRECTION_OFF:
         begin
            rdata_d = pio_pad2(d_dir);
         end
         PIO_PORT_E_DIRECTION_OFF:
         begin
            rdata_d = pio_pad2(e_dir);
         end
         default:
         begin
            rdata_d = PIO_UNMAPPED_RD;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_q <= PIO_RDATA_RST;
      end
      else if (rd_in)
      begin
         rdata_q <= rdata_d;
      end
      else
      begin
         rdata_q <= PIO_RDATA_RST;
      end
   end

   assign rdata_out = rdata_q;

   // Pin drivers; pin two carries the bus clock itself when enabled,
   // so that one bit cannot come from a flip-flop
   always_comb
   begin
      port_c_out = c_latch;
      port_c_oe_out = c_oe_q; // RL1 RL2
      if (clk_en_q)
      begin
         port_c_out[PIO_CLK_PIN] = ref_clk_in; // RL2
      end
   end

   assign port_d_out = d_latch; // RL7
   assign port_d_oe_out = d_dir; // RL8
   assign port_e_out = e_latch;
   assign port_e_oe_out = e_dir; // RL11

   default clocking pio_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   c_dir_write_a: assert property ( // RL1
      wr_c_dir |=> (port_c_oe_out[1:0] == $past(wdata_in[1:0])) &&
         (port_c_oe_out[4:3] == $past(wdata_in[4:3])))
      else $error("port C enables do not follow direction write");

   c_clk_drive_a: assert property ( // RL2
      wr_c_dir && wdata_in[PIO_CLK_OUT_BIT] |=>
         port_c_oe_out[PIO_CLK_PIN] && clk_en_q)
      else $error("clock enable did not drive pin two");

   c_reset_input_a: assert property ( // RL3
      disable iff (1'b0)
      !rst_n_in |-> (port_c_oe_out == 5'h00) && !clk_en_q)
      else $error("port C not all inputs during reset");

   c_read_mix_a: assert property ( // RL4
      rd_in && addr_in == PIO_PORT_C_PIN_DATA_OFF && !clk_en_q |=>
         rdata_out == {3'h0, $past((c_dir & c_latch) |
            (~c_dir & port_c_in))})
      else $error("port C read mixes latch and pin wrongly");

   d_latch_write_a: assert property ( // RL5
      wr_d_data && d_dir == 2'h0 ##1 !wr_in ##1 rd_in &&
         addr_in == PIO_PORT_D_DIRECTION_OFF |->
         d_latch == $past(wdata_in[1:0], 2) && d_dir == 2'h0)
      else $error("port D latch missed write in input mode");

   e_latch_keep_a: assert property ( // RL5
      wr_e_data ##1 !wr_e_data [*2] |->
         e_latch == $past(wdata_in[1:0], 2))
      else $error("port E latch lost its written value");

   d_dir_write_a: assert property ( // RL8
      wr_d_dir |=> port_d_oe_out == $past(wdata_in[1:0]))
      else $error("port D enables do not follow direction write");

   d_reset_input_a: assert property ( // RL9
      disable iff (1'b0)
      !rst_n_in |-> port_d_oe_out == 2'h0)
      else $error("port D not inputs during reset");

   d_read_mix_a: assert property ( // RL10
      rd_in && addr_in == PIO_PORT_D_PIN_DATA_OFF |=>
         rdata_out == {6'h00, $past((d_dir & d_latch) |
            (~d_dir & port_d_in))})
      else $error("port D read mixes latch and pin wrongly");

   e_dir_write_a: assert property ( // RL11
      wr_e_dir |=> port_e_oe_out == $past(wdata_in[1:0]) &&
         port_e_out == $past(e_latch))
      else $error("port E enables do not follow direction write");

   e_reset_input_a: assert property ( // RL13
      disable iff (1'b0)
      !rst_n_in |-> port_e_oe_out == 2'h0)
      else $error("port E not inputs during reset");

   e_read_mix_a: assert property ( // RL14
      rd_in && addr_in == PIO_PORT_E_PIN_DATA_OFF |=>
         rdata_out == {6'h00, $past((e_dir & e_latch) |
            (~e_dir & port_e_in))})
      else $error("port E read mixes latch and pin wrongly");

   c_clk_read_a: assert property ( // RL16
      clk_en_q && rd_in && addr_in == PIO_PORT_C_PIN_DATA_OFF |=>
         !rdata_out[PIO_CLK_PIN] && rdata_out[7:5] == 3'h0)
      else $error("pin two read not zero while clock out");

   c_dir_read_a: assert property ( // RL16
      rd_in && addr_in == PIO_PORT_C_DIRECTION_OFF |=>
         rdata_out[PIO_CLK_OUT_BIT] == $past(clk_en_q) &&
         rdata_out[6:5] == 2'h0)
      else $error("direction C read does not show clock enable");

   rd_idle_zero_a: assert property (
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data present without a read");

   c_oe_follow_a: assert property ( // RL1
      !clk_en_q |-> port_c_oe_out == c_dir)
      else $error("port C enables differ from direction bits");

   // Sampled just before the rising edge, so the clock is low there
   c_clk_hold_a: assert property ( // RL2
      clk_en_q |-> port_c_oe_out[PIO_CLK_PIN] &&
         !port_c_out[PIO_CLK_PIN])
      else $error("pin two does not carry the clock");

   d_data_write_a: assert property ( // RL7
      wr_d_data |=> port_d_out == $past(wdata_in[1:0]))
      else $error("port D latch did not take the write");

   latch_reset_keep_a: assert property ( // RL12 RL15
      disable iff (1'b0)
      rst_n_in && !wr_in ##1 !rst_n_in && !wr_in |=>
         c_latch == $past(c_latch, 2) && e_latch == $past(e_latch, 2))
      else $error("data latches changed across reset");
endmodule
`default_nettype wire

/* dv/tb_parallel_io_ports_c_d_e.sv */
/*
 Self-checking bench for the port C, D and E block: reset state,
 pin drive, read view, bus clock on port C pin two, unmapped access.
 Assumes the register port of pio_ports and a fixed random seed.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_io_ports_c_d_e;
   import pio_pkg::*;
   logic ref_clk_in, rst_n_in, wr_in, rd_in;
   logic [7:0] addr_in, wdata_in, rdata_out;
   logic [4:0] port_c_in, port_c_out, port_c_oe_out;
   logic [1:0] port_d_in, port_d_out, port_d_oe_out;
   logic [1:0] port_e_in, port_e_out, port_e_oe_out;
   int miscompares, compares;
   logic [7:0] lat [3];
   logic [7:0] dir [3];
   localparam logic [7:0] DOFF [3] = '{PIO_PORT_C_PIN_DATA_OFF,
      PIO_PORT_D_PIN_DATA_OFF, PIO_PORT_E_PIN_DATA_OFF};
   localparam logic [7:0] ROFF [3] = '{PIO_PORT_C_DIRECTION_OFF,
      PIO_PORT_D_DIRECTION_OFF, PIO_PORT_E_DIRECTION_OFF};
   localparam logic [7:0] DMSK [3] = '{8'h1f, 8'h03, 8'h03};
   localparam logic [7:0] RMSK [3] = '{8'h9f, 8'h03, 8'h03};

   pio_ports DUT (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out),
      .port_c_in(port_c_in), .port_c_out(port_c_out),
      .port_c_oe_out(port_c_oe_out),
      .port_d_in(port_d_in), .port_d_out(port_d_out),
      .port_d_oe_out(port_d_oe_out),
      .port_e_in(port_e_in), .port_e_out(port_e_out),
      .port_e_oe_out(port_e_oe_out)
   );

   initial
   begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   task check(input string nm, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task print_verdict;
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task wr(input logic [7:0] a, d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(negedge ref_clk_in);
      d = rdata_out;
   endtask

   // Software order: data latch first, then direction
   task wrp(input int p, input logic [7:0] d, input bit is_dir);
      if (is_dir)
         dir[p] = d & RMSK[p];
      else
         lat[p] = d & DMSK[p];
      wr(is_dir ? ROFF[p] : DOFF[p], d);
   endtask

   function automatic logic [7:0] view(input int p);
      logic [7:0] pin;
      logic [7:0] v;
      pin = (p == 0) ? {3'h0, port_c_in} :
         (p == 1) ? {6'h0, port_d_in} : {6'h0, port_e_in};
      v = ((lat[p] & dir[p]) | (pin & ~dir[p])) & DMSK[p];
      if (p == 0 && dir[0][PIO_CLK_OUT_BIT])
         v[PIO_CLK_PIN] = 1'b0;
      return v;
   endfunction

   // Sampled just after the falling edge, once pin two has gone low
   task chk_pins;
      logic [7:0] e;
      @(negedge ref_clk_in);
      #1;
      e = dir[0] & 8'h1f;
      e[PIO_CLK_PIN] = e[PIO_CLK_PIN] | dir[0][PIO_CLK_OUT_BIT];
      check("c oe", {3'h0, port_c_oe_out}, e);
      check("d oe", {6'h0, port_d_oe_out}, dir[1]);
      check("e oe", {6'h0, port_e_oe_out}, dir[2]);
      e = lat[0];
      if (dir[0][PIO_CLK_OUT_BIT])
         e[PIO_CLK_PIN] = 1'b0;
      check("c out", {3'h0, port_c_out}, e);
      check("d out", {6'h0, port_d_out}, lat[1]);
      check("e out", {6'h0, port_e_out}, lat[2]);
   endtask

   task chk_regs;
      logic [7:0] r;
      for (int p = 0; p < 3; p++)
      begin
         rd(ROFF[p], r);
         check("dir", r, dir[p]);
         rd(DOFF[p], r);
         check("data", r, view(p));
      end
   endtask

   initial
   begin
      logic [7:0] r;
      logic [31:0] x;
      int p;
      rst_n_in = 1'b1;
      addr_in = 8'h00;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      port_c_in = 5'h00;
      port_d_in = 2'h0;
      port_e_in = 2'h0;
      miscompares = 0;
      compares = 0;
      void'($urandom(58));
      // Reset falls after time zero so every flop sees the edge
      #1 rst_n_in = 1'b0;
      repeat (20) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      for (p = 0; p < 3; p++)
      begin
         dir[p] = 8'h00;
         wrp(p, 8'hff, 1'b0);
      end
      chk_pins;
      chk_regs;
      for (int i = 0; i < 40; i++)
      begin
         x = $urandom;
         p = $urandom_range(2);
         @(posedge ref_clk_in);
         port_c_in <= x[4:0];
         port_d_in <= x[6:5];
         port_e_in <= x[8:7];
         wrp(p, (i < 3) ? 8'h00 : x[23:16], 1'b0);
         wrp(p, (i < 2) ? 8'h7f : (x[31:24] & 8'h7f), 1'b1);
         chk_pins;
         wrp(p, ~x[23:16], 1'b0);
         chk_pins;
         chk_regs;
      end
      // Bus clock on pin two: driven, toggling, reads 0
      @(posedge ref_clk_in);
      port_c_in <= 5'h1f;
      wrp(0, 8'h04, 1'b0);
      wrp(0, 8'h80, 1'b1);
      chk_pins;
      @(posedge ref_clk_in);
      #1 check("c clk", {7'h0, port_c_out[PIO_CLK_PIN]}, 8'h01);
      chk_regs;
      wrp(0, 8'h1b, 1'b0);
      chk_pins;
      chk_regs;
      // Unmapped place: write ignored, read 0; then nothing after a port D direction read
      wr(8'h40, 8'hff);
      rd(8'h40, r);
      check("unmapped", r, PIO_UNMAPPED_RD);
      rd(ROFF[1], r);
      @(negedge ref_clk_in);
      check("rdata idle", rdata_out, 8'h00);
      chk_pins;
      // Mid-run reset with clock output on: latches must survive
      wrp(1, 8'h01, 1'b0);
      wrp(2, 8'h02, 1'b0);
      wrp(1, 8'h03, 1'b1);
      wrp(2, 8'h03, 1'b1);
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      for (p = 0; p < 3; p++)
         dir[p] = 8'h00;
      chk_pins;
      chk_regs;
      // Latch write in input mode, direction read straight after
      wrp(1, 8'h02, 1'b0);
      rd(ROFF[1], r);
      check("d dir", r, dir[1]);
      rd(DOFF[1], r);
      check("d data", r, view(1));
      chk_pins;
      print_verdict;
   end
endmodule
`default_nettype wire
